// [verilog/gcr_pkg.sv]
// Package for the global configuration register group.
// Assumes an 8-bit configuration register port with one-cycle strobes.
package gcr_pkg;
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 8;
    localparam logic [7:0]  ADDR_SWRST     = 8'h02;
    localparam logic [7:0]  ADDR_LDN       = 8'h07;
    localparam logic [7:0]  ADDR_TRIG_A    = 8'h10;
    localparam logic [7:0]  ADDR_TRIG_B    = 8'h11;
    localparam logic [7:0]  ADDR_UNLOCK    = 8'h26;
    localparam int          SWRST_BIT      = 0;
    localparam int          UNLOCK_BIT     = 4;
    localparam logic [7:0]  LDN_RESET      = 8'h00;
    localparam logic [7:0]  TRIG_A_RESET   = 8'hFF;
    localparam logic [7:0]  TRIG_B_RESET   = 8'hFF;
    localparam logic [7:0]  TRIG_B_MASK    = 8'hFE;
    localparam logic [7:0]  UNLOCK_RESET   = 8'h00;
    localparam int          SWRST_PULSE_CY = 1;
endpackage

// [verilog/gcr_pulse.sv]
// Self-clearing pulse generator for the software reset command.
// Assumes a synchronous trigger on the same clock.
`timescale 1ns/100ps
module gcr_pulse #(
    parameter int WIDTH = 1
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic trigger,
    output logic      pulse
);
    import gcr_pkg::*;

    logic [7:0] count;
    logic [7:0] next_count;
    logic       next_pulse;

    initial begin
        if (WIDTH < 1 || WIDTH > 255) begin
            $error("gcr_pulse: WIDTH out of range");
        end
    end

    // Reload on trigger, count down otherwise; nothing is stored afterwards
    always_comb begin
        next_count = count;
        if (trigger) begin
            next_count = 8'(WIDTH);
        end else if (count != 8'h00) begin
            next_count = count - 8'h01;
        end
        next_pulse = (next_count != 8'h00);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 8'h00;
            pulse <= 1'b0;
        end else begin
            count <= next_count;
            pulse <= next_pulse;
        end
    end
endmodule

// [verilog/gcr_top.sv]
// Global configuration registers: software reset, device select, IRQ trigger types.
// Assumes a plain register port on clk; rstn is the host bus reset.
//
// Operation
// [R1] Writing one to bit 0 of the reset command starts a configuration reset.
// [R2] Reset command at 0x02 is write-only; bits 7..1 ignored, reads zero.
// [R3] Logical device number at 0x07, read/write, eight bits, resets to zero.
// [R4] Host bus reset returns every register here to its default.
// [R5] Trigger type register at 0x10 resets to FFh; 0 edge, 1 level per bit.
// [R6] Trigger type register at 0x11 resets to FFh; bits 7..1 act, bit 0 reserved.
// [R7] Software sets unlock bit 4 before touching either trigger type register.
// [R8] Software reset is a self-clearing pulse; the command leaves no state.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/100ps
module gcr_top (
    input  wire logic                       clk,
    input  wire logic                       rstn,
    input  wire logic [gcr_pkg::ADDR_W-1:0] addr,
    input  wire logic [gcr_pkg::DATA_W-1:0] wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic      [gcr_pkg::DATA_W-1:0] rdata,
    output logic                            soft_reset,
    output logic      [7:0]                 logical_device,
    output logic      [7:0]                 trig_level_a,
    output logic      [7:0]                 trig_level_b
);
    import gcr_pkg::*;

    logic       rst_meta;
    logic       rst_sync;
    logic [7:0] ldn;
    logic [7:0] trig_a;
    logic [7:0] trig_b;
    logic [7:0] unlock;
    logic [7:0] next_ldn;
    logic [7:0] next_trig_a;
    logic [7:0] next_trig_b;
    logic [7:0] next_unlock;
    logic [7:0] next_rdata;
    logic       swrst_req;
    logic       swrst_pulse;
    logic       cfg_rst_n;

    // Reset release through two flops so every register leaves reset together
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    assign swrst_req = wr && (addr == ADDR_SWRST) && wdata[SWRST_BIT]; // [R1] [R2]

    // Pulse ends by itself, so nothing stays latched at the command address
    gcr_pulse #(
        .WIDTH (SWRST_PULSE_CY)
    ) u_pulse (
        .clk     (clk),
        .rst_n   (rst_sync),
        .trigger (swrst_req),
        .pulse   (swrst_pulse)
    ); // [R8]

    // Software reset also restores this group; bus reset takes priority
    assign cfg_rst_n = rst_sync;

    // Register updates; trigger type writes only land while unlocked, soft reset restores them regardless
    always_comb begin
        next_ldn    = ldn;
        next_trig_a = trig_a;
        next_trig_b = trig_b;
        next_unlock = unlock;
        if (swrst_pulse) begin
            next_ldn    = LDN_RESET;
            next_trig_a = TRIG_A_RESET;
            next_trig_b = TRIG_B_RESET;
            next_unlock = UNLOCK_RESET;
        end else if (wr) begin
            case (addr)
                ADDR_LDN:    next_ldn = wdata; // [R3]
                ADDR_UNLOCK: next_unlock = wdata;
                ADDR_TRIG_A: begin
                    if (unlock[UNLOCK_BIT]) begin
                        next_trig_a = wdata; // [R5] [R7]
                    end
                end
                ADDR_TRIG_B: begin
                    if (unlock[UNLOCK_BIT]) begin
                        next_trig_b = (wdata & TRIG_B_MASK) | (~TRIG_B_MASK & TRIG_B_RESET); // [R6] [R7]
                    end
                end
                default: next_ldn = ldn;
            endcase
        end
    end

    // Read mux; write-only, locked and unmapped addresses read zero
    always_comb begin
        next_rdata = 8'h00;
        if (rd) begin
            case (addr)
                ADDR_LDN:    next_rdata = ldn;
                ADDR_UNLOCK: next_rdata = unlock;
                ADDR_TRIG_A: next_rdata = unlock[UNLOCK_BIT] ? trig_a : 8'h00;
                ADDR_TRIG_B: next_rdata = unlock[UNLOCK_BIT] ? (trig_b & TRIG_B_MASK) : 8'h00;
                ADDR_SWRST:  next_rdata = 8'h00; // [R2]
                default:     next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge cfg_rst_n) begin
        if (!cfg_rst_n) begin
            ldn    <= LDN_RESET;    // [R4]
            trig_a <= TRIG_A_RESET; // [R4]
            trig_b <= TRIG_B_RESET;
            unlock <= UNLOCK_RESET;
            rdata  <= 8'h00;
        end else begin
            ldn    <= next_ldn;
            trig_a <= next_trig_a;
            trig_b <= next_trig_b;
            unlock <= next_unlock;
            rdata  <= next_rdata;
        end
    end

    // Outputs registered copies for the rest of the chip
    always_ff @(posedge clk or negedge cfg_rst_n) begin
        if (!cfg_rst_n) begin
            soft_reset     <= 1'b0;
            logical_device <= LDN_RESET;
            trig_level_a   <= TRIG_A_RESET;
            trig_level_b   <= TRIG_B_RESET & TRIG_B_MASK; // [R6] Reserved bit never shows
        end else begin
            soft_reset     <= swrst_pulse;
            logical_device <= ldn;
            trig_level_a   <= trig_a;
            trig_level_b   <= trig_b & TRIG_B_MASK;
        end
    end
endmodule

// [verification/gcr_top_monitor.sv]
// Checker for the global configuration registers.
// Assumes the gcr_top port timing: outputs mirror registers one cycle late.
`timescale 1ns/100ps
module gcr_top_monitor (
    input wire logic       clk,
    input wire logic       rstn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic       soft_reset,
    input wire logic [7:0] logical_device,
    input wire logic [7:0] trig_level_a,
    input wire logic [7:0] trig_level_b
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Reset command with bit 0 set, then a one-cycle pulse
    sequence s_go;
        wr && addr == 8'h02 && wdata[0];
    endsequence
    sequence s_pulse;
        soft_reset ##1 !soft_reset;
    endsequence
    a_pulse_once: assert property (s_go |-> ##2 s_pulse)
        else $error("reset pulse missing");
    a_pulse_cause: assert property (soft_reset |-> $past(wr && addr == 8'h02 && wdata[0], 2))
        else $error("reset pulse without command");
    a_cmd_reads: assert property (rd && addr == 8'h02 |=> rdata == 8'h00)
        else $error("reset command readable");
    a_ldn_follow: assert property (wr && addr == 8'h07 |-> ##2 logical_device == $past(wdata, 2))
        else $error("device number not stored");
    a_trig_bit0: assert property (trig_level_b[0] == 1'b0)
        else $error("reserved trigger bit set");
    // Trigger output A moves only after its own write or a soft reset
    a_trig_cause: assert property ($changed(trig_level_a) |-> $past(wr && addr == 8'h10, 2) || $past(soft_reset))
        else $error("trigger type moved alone");
    a_soft_dflt: assert property (soft_reset |=> logical_device == 8'h00 && trig_level_a == 8'hFF)
        else $error("defaults not restored");
endmodule
bind gcr_top gcr_top_monitor i_gcr_top_monitor (.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .soft_reset(soft_reset),
    .logical_device(logical_device), .trig_level_a(trig_level_a), .trig_level_b(trig_level_b));

// [verification/tb_top.sv]
// Self-checking bench for the global configuration registers.
// Assumes read data stand one cycle after the read strobe.
`timescale 1ns/100ps
module tb_top;
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] rdata;
    logic       soft_reset;
    logic [7:0] logical_device;
    logic [7:0] trig_level_a;
    logic [7:0] trig_level_b;
    int         fails = 0;
    int         checked = 0;
    gcr_top i_gcr_top (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .soft_reset(soft_reset), .logical_device(logical_device),
        .trig_level_a(trig_level_a), .trig_level_b(trig_level_b));
    // 200 MHz clock
    always #2.5 clk = ~clk;
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Data are only valid in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic pulses(input logic [7:0] exp);
        logic [7:0] n;
        n = 8'h00;
        repeat (4) begin
            @(posedge clk);
            #1 n += {7'h00, soft_reset};
        end
        chk(n, exp);
    endtask
    task automatic t_ldn;
        wr_reg(8'h07, 8'hA5);
        rd_chk(8'h07, 8'hA5);
        rd_chk(8'h02, 8'h00);
        rd_chk(8'h03, 8'h00);
        chk(logical_device, 8'hA5);
    endtask
    // Locked writes must be dropped; unlocked ones land
    task automatic t_trig;
        wr_reg(8'h10, 8'h00);
        rd_chk(8'h26, 8'h00);
        chk(trig_level_a, 8'hFF);
        wr_reg(8'h26, 8'h10);
        wr_reg(8'h10, 8'h5A);
        wr_reg(8'h11, 8'hFF);
        rd_chk(8'h10, 8'h5A);
        rd_chk(8'h11, 8'hFE);
        chk(trig_level_a, 8'h5A);
        chk(trig_level_b, 8'hFE);
    endtask
    task automatic t_swrst;
        wr_reg(8'h02, 8'hFE);
        pulses(8'h00);
        wr_reg(8'h02, 8'h01);
        pulses(8'h01);
        chk(logical_device, 8'h00);
        chk(trig_level_a, 8'hFF);
        rd_chk(8'h26, 8'h00);
    endtask
    task automatic complete_run;
        $display("fails=%0d checked=%0d", fails, checked);
        if (fails == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        chk(trig_level_b, 8'hFE);
        rd_chk(8'h07, 8'h00);
        t_ldn();
        t_trig();
        t_swrst();
        complete_run();
    end
    // Whole run needs well under a microsecond
    initial begin
        #20000;
        fails++;
        complete_run();
    end
endmodule
